/* shared/belane_pkg.sv */
package belane_pkg;
  // -------------------------------------------------------------------------
  // access sizes and device widths
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    BELANE_SZ_BYTE = 2'h0,
    BELANE_SZ_WORD = 2'h1,
    BELANE_SZ_LONG = 2'h2,
    BELANE_SZ_QUAD = 2'h3
  } belane_size_t;

  typedef enum logic [1:0] {
    BELANE_BW_8  = 2'h0,
    BELANE_BW_16 = 2'h1,
    BELANE_BW_32 = 2'h2
  } belane_width_t;

  typedef enum logic [1:0] {
    BELANE_ST_IDLE = 2'h1,
    BELANE_ST_BUSY = 2'h2
  } belane_state_t;

  localparam int BELANE_AW = 29;
  localparam int BELANE_DW = 64;
  localparam int BELANE_LW = 32;
  localparam int BELANE_NLANE = 4;
  localparam int BELANE_CW = 4;
  localparam logic [3:0] BELANE_STB_NONE = 4'h0;
  localparam logic [3:0] BELANE_STB_ALL = 4'hf;
  localparam logic [3:0] BELANE_STB_L0 = 4'h1;
  localparam logic [3:0] BELANE_STB_L10 = 4'h3;
  localparam logic [3:0] BELANE_STB_L32 = 4'hc;
endpackage

/* logic/belane_align.sv */
// Notes on behaviour
// - 32-bit device: byte at offset 0..3 on lanes 3..0, only that strobe.
// - 32-bit device: word/longword in one cycle; word offset 0 lanes 3-2, offset 2 lanes 1-0.
// - 32-bit device: quadword is two cycles, bits 63-32 first, all strobes.
// - 16-bit device: even byte lane 1, odd byte lane 0; word lanes 1-0.
// - 16-bit device: long two, quad four cycles, address plus two, MS first.
// - 8-bit device: every byte on lane 0, only strobe 0; byte one cycle.
// - 8-bit device: word 2, long 4, quad 8 cycles ascending, MS byte first.
`timescale 1ns/1ps
module belane_align (
  input wire logic sys_clk_i, // system clock
  input wire logic reset_i, // sync reset, active high
  input wire logic req_valid_i, // cpu access request
  output logic req_ready_o, // request accepted this cycle
  input wire logic req_write_i, // 1 write, 0 read
  input wire belane_pkg::belane_size_t req_size_i, // access size
  input wire logic [belane_pkg::BELANE_AW-1:0] req_addr_i, // byte address
  input wire logic [belane_pkg::BELANE_DW-1:0] req_wdata_i, // right-aligned write data
  input wire belane_pkg::belane_width_t dev_width_i, // external device width
  output logic rsp_valid_o, // access complete pulse
  output logic [belane_pkg::BELANE_DW-1:0] rsp_rdata_o, // right-aligned read data
  output logic cyc_valid_o, // external bus cycle active
  input wire logic cyc_done_i, // external cycle finished
  output logic cyc_write_o, // cycle direction
  output logic [belane_pkg::BELANE_AW-1:0] cyc_addr_o, // cycle byte address
  output logic [belane_pkg::BELANE_LW-1:0] bus_wdata_o, // lane write data
  input wire logic [belane_pkg::BELANE_LW-1:0] bus_rdata_i, // lane read data
  output logic lane3_byte_strobe_o, // D31-24 strobe
  output logic lane2_byte_strobe_o, // D23-16 strobe
  output logic lane1_byte_strobe_o, // D15-8 strobe
  output logic lane0_byte_strobe_o // D7-0 strobe
);
  import belane_pkg::*;

  // -------------------------------------------------------------------------
  // access state
  // -------------------------------------------------------------------------
  belane_state_t state;
  belane_size_t size;
  belane_width_t width;
  logic write;
  logic [BELANE_AW-1:0] base;
  logic [BELANE_DW-1:0] wdata;
  logic [BELANE_DW-1:0] rdata;
  logic [BELANE_CW-1:0] idx;
  logic [BELANE_CW-1:0] last;

  // -------------------------------------------------------------------------
  // cycle count and step per width and size
  // -------------------------------------------------------------------------
  // bytes per access as log2, bytes per cycle as log2; cycles = 2^(a-b), one cycle when a <= b
  wire [1:0] sz_log = size;
  wire [1:0] bw_log = (width == BELANE_BW_32) ? 2'h2 : (width == BELANE_BW_16) ? 2'h1 : 2'h0;
  wire [1:0] nlog = (sz_log > bw_log) ? sz_log - bw_log : 2'h0;
  wire [BELANE_CW-1:0] ncyc_m1 = BELANE_CW'((4'h1 << nlog) - 4'h1);
  wire [1:0] req_bw_log = (dev_width_i == BELANE_BW_32) ? 2'h2 :
                          (dev_width_i == BELANE_BW_16) ? 2'h1 : 2'h0;
  wire [1:0] req_sz_log = req_size_i;
  wire [1:0] req_nlog = (req_sz_log > req_bw_log) ? req_sz_log - req_bw_log : 2'h0;
  wire [BELANE_CW-1:0] req_last = BELANE_CW'((4'h1 << req_nlog) - 4'h1);

  // address of this cycle: base aligned plus idx times bus bytes, ascending
  wire [BELANE_AW-1:0] step = BELANE_AW'(idx) << bw_log;
  wire [BELANE_AW-1:0] addr_now = base + step;
  wire [1:0] off = addr_now[1:0];

  // -------------------------------------------------------------------------
  // lane strobes
  // -------------------------------------------------------------------------
  // narrow unit per cycle is min(access, bus) bytes
  wire [1:0] unit_log = (sz_log < bw_log) ? sz_log : bw_log;
  wire [3:0] mask_unit = (unit_log == 2'h0) ? 4'h1 : (unit_log == 2'h1) ? 4'h3 : 4'hf;
  // big-endian: lowest offset sits on the highest lane
  wire [1:0] lane_sh = (width == BELANE_BW_32) ? 2'h3 - off - {1'b0, mask_unit[1]} -
                       {mask_unit[3], mask_unit[3]} + {mask_unit[3], mask_unit[3]} :
                       (width == BELANE_BW_16) ? {1'b0, ~off[0] & ~mask_unit[1]} : 2'h0;
  wire [1:0] lane_lo = (width == BELANE_BW_32 && mask_unit == BELANE_STB_ALL) ? 2'h0 : lane_sh;
  wire [3:0] strobe = (state == BELANE_ST_BUSY) ? 4'(mask_unit << lane_lo) : BELANE_STB_NONE;

  // unit of data for this cycle: most significant unit first
  wire [BELANE_CW-1:0] rev = ncyc_m1 - idx;
  // widen before the add: a two-bit sum would wrap five bits-log down to one
  wire [2:0] unit_bits_log = {1'b0, unit_log} + 3'h3;
  wire [6:0] bit_sh = 7'(rev) << unit_bits_log;
  wire [BELANE_LW-1:0] unit_w = BELANE_LW'(wdata >> bit_sh);
  wire [5:0] lane_bit = 6'(lane_lo) << 3;
  wire [BELANE_LW-1:0] lane_mask = {{8{strobe[3]}}, {8{strobe[2]}}, {8{strobe[1]}}, {8{strobe[0]}}};
  wire [BELANE_LW-1:0] next_wlane = (unit_w << lane_bit) & lane_mask;
  wire [BELANE_LW-1:0] unit_r = (bus_rdata_i & lane_mask) >> lane_bit;
  wire [BELANE_DW-1:0] unit_mask = (unit_log == 2'h0) ? 64'h0000_0000_0000_00ff :
                                   (unit_log == 2'h1) ? 64'h0000_0000_0000_ffff :
                                   64'h0000_0000_ffff_ffff;
  wire [BELANE_DW-1:0] next_rdata = (rdata & ~(unit_mask << bit_sh)) |
                                    ((BELANE_DW'(unit_r) & unit_mask) << bit_sh);

  wire idle = (state == BELANE_ST_IDLE);
  wire take = idle & req_valid_i;
  wire final_cyc = (state == BELANE_ST_BUSY) & cyc_done_i & (idx == last);
  wire [BELANE_AW-1:0] align_mask = ~(BELANE_AW'(4'h1 << req_sz_log) - BELANE_AW'(1));

  assign req_ready_o = idle;
  assign cyc_valid_o = (state == BELANE_ST_BUSY);
  assign cyc_write_o = write;
  assign cyc_addr_o = addr_now;
  assign bus_wdata_o = write ? next_wlane : '0;
  assign {lane3_byte_strobe_o, lane2_byte_strobe_o, lane1_byte_strobe_o,
          lane0_byte_strobe_o} = strobe;

  // -------------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------------
  // requests are captured once; width is latched so a mid-access change is harmless
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= BELANE_ST_IDLE;
      size <= BELANE_SZ_BYTE;
      width <= BELANE_BW_8;
      write <= 1'b0;
      base <= '0;
      wdata <= '0;
      rdata <= '0;
      idx <= '0;
      last <= '0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= final_cyc;
      unique case (state)
        BELANE_ST_IDLE: begin
          if (take) begin
            state <= BELANE_ST_BUSY;
            size <= req_size_i;
            width <= dev_width_i;
            write <= req_write_i;
            base <= req_addr_i & align_mask;
            wdata <= req_wdata_i;
            rdata <= '0;
            idx <= '0;
            last <= req_last;
          end
        end
        BELANE_ST_BUSY: begin
          if (cyc_done_i) begin
            rdata <= next_rdata;
            idx <= idx + 4'h1;
            if (idx == last) begin
              state <= BELANE_ST_IDLE;
              rsp_rdata_o <= next_rdata;
            end
          end
        end
        default: state <= BELANE_ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  AST_BYTE8: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && width == BELANE_BW_8 |-> strobe == BELANE_STB_L0)
    else $error("8-bit device strobe not lane 0");
  AST_WIDE16: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && width == BELANE_BW_16 && size != BELANE_SZ_BYTE |-> strobe == BELANE_STB_L10)
    else $error("16-bit wide access strobes wrong");
  AST_BYTE16: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && width == BELANE_BW_16 && size == BELANE_SZ_BYTE |->
    strobe == (off[0] ? 4'h1 : 4'h2))
    else $error("16-bit byte lane wrong");
  AST_BYTE32: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && width == BELANE_BW_32 && size == BELANE_SZ_BYTE |->
    strobe == 4'(4'h8 >> off))
    else $error("32-bit byte lane wrong");
  AST_WORD32: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && width == BELANE_BW_32 && size == BELANE_SZ_WORD |->
    strobe == (off[1] ? BELANE_STB_L10 : BELANE_STB_L32) && last == 4'h0)
    else $error("32-bit word lanes wrong");
  AST_QUAD32: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && width == BELANE_BW_32 && size == BELANE_SZ_QUAD |->
    strobe == BELANE_STB_ALL && last == 4'h1)
    else $error("32-bit quadword split wrong");
  AST_ASCEND: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && cyc_done_i && idx != last |=>
    cyc_addr_o == $past(cyc_addr_o) + (BELANE_AW'(1) << bw_log))
    else $error("cycle address not ascending");
  AST_COUNT8: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    take && dev_width_i == BELANE_BW_8 && req_size_i == BELANE_SZ_QUAD |=> last == 4'h7)
    else $error("8-bit quadword not eight cycles");
  AST_DONTCARE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (bus_wdata_o & ~lane_mask) == '0)
    else $error("unstrobed lane driven");

  // cycle counts fixed at take, one per split of the access
  AST_BYTE1: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    take && req_size_i == BELANE_SZ_BYTE |=> last == 4'h0)
    else $error("byte access not one cycle");
  AST_LONG32: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    take && dev_width_i == BELANE_BW_32 && req_size_i == BELANE_SZ_LONG |=> last == 4'h0)
    else $error("32-bit longword not one cycle");
  AST_WORD16: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    take && dev_width_i == BELANE_BW_16 && req_size_i == BELANE_SZ_WORD |=> last == 4'h0)
    else $error("16-bit word not one cycle");
  AST_LONG16: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    take && dev_width_i == BELANE_BW_16 && req_size_i == BELANE_SZ_LONG |=> last == 4'h1)
    else $error("16-bit longword not two cycles");
  AST_QUAD16: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    take && dev_width_i == BELANE_BW_16 && req_size_i == BELANE_SZ_QUAD |=> last == 4'h3)
    else $error("16-bit quadword not four cycles");
  AST_WORD8: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    take && dev_width_i == BELANE_BW_8 && req_size_i == BELANE_SZ_WORD |=> last == 4'h1)
    else $error("8-bit word not two cycles");
  AST_LONG8: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    take && dev_width_i == BELANE_BW_8 && req_size_i == BELANE_SZ_LONG |=> last == 4'h3)
    else $error("8-bit longword not four cycles");

  // the most significant unit leads every split quadword write
  AST_MSB32: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && cyc_write_o && width == BELANE_BW_32 && size == BELANE_SZ_QUAD &&
    idx == 4'h0 |-> bus_wdata_o == wdata[63:32])
    else $error("32-bit quadword high half not first");
  AST_MSB16: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && cyc_write_o && width == BELANE_BW_16 && size == BELANE_SZ_QUAD &&
    idx == 4'h0 |-> bus_wdata_o[15:0] == wdata[63:48])
    else $error("16-bit quadword top halfword not first");
  AST_MSB8: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cyc_valid_o && cyc_write_o && width == BELANE_BW_8 && size == BELANE_SZ_QUAD &&
    idx == 4'h0 |-> bus_wdata_o[7:0] == wdata[63:56])
    else $error("8-bit quadword top byte not first");
endmodule // belane_align

/* verif/belane_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// far-side memory with big-endian lanes
// ----------------------------------------
module belane_mem_model (
  input wire logic sys_clk_i, // clock
  input wire logic cyc_valid_i, // cycle active
  input wire logic [28:0] cyc_addr_i, // cycle address
  input wire logic [3:0] stb_i, // lane strobes
  input wire logic cyc_write_i, // direction
  input wire logic [31:0] wdata_i, // lane write data
  input wire logic [1:0] width_i, // port width code
  input wire logic [1:0] slow_i, // wait cycles
  output logic cyc_done_o, // cycle ends
  output logic [31:0] rdata_o, // lane read data
  output int errs_o // faults seen
);
  logic [7:0] mem [0:255];
  logic [1:0] wait_q = 2'h0;
  logic [7:0] tick = 8'h0;
  int wb;
  assign wb = 1 << width_i;
  // lane k holds byte base+wb-1-k, msb lane at the lowest address
  function automatic int lb(int k);
    return ((int'(cyc_addr_i) & ~(wb - 1)) + wb - 1 - k) & 255;
  endfunction
  // unstrobed lanes carry a moving pattern, never a stale byte
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      rdata_o[k*8 +: 8] = (cyc_valid_i && stb_i[k]) ? mem[lb(k)] : ~tick;
    end
  end
  initial begin
    cyc_done_o = 1'b0;
    errs_o = 0;
  end
  // store strobed lanes only; a strobe beyond the port is a fault
  always @(posedge sys_clk_i) begin
    tick <= tick + 8'h1;
    if (cyc_valid_i && cyc_done_o) begin
      for (int k = 0; k < 4; k++) begin
        if (stb_i[k] && cyc_write_i) mem[lb(k)] <= wdata_i[k*8 +: 8];
        if (stb_i[k] && k >= wb) errs_o <= errs_o + 1;
      end
    end
    #1;
    cyc_done_o <= cyc_valid_i && !cyc_done_o && wait_q == slow_i;
    wait_q <= (cyc_valid_i && !cyc_done_o && wait_q != slow_i) ? wait_q + 2'h1 : 2'h0;
  end
endmodule // belane_mem_model

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import belane_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
  belane_size_t req_size_i = BELANE_SZ_BYTE;
  belane_width_t dev_width_i = BELANE_BW_32;
  logic [28:0] req_addr_i = 29'h0, cyc_addr_o, exp_addr = 29'h0;
  logic [63:0] req_wdata_i = 64'h0, rsp_rdata_o, rd;
  logic req_ready_o, rsp_valid_o, cyc_valid_o, cyc_done_i, cyc_write_o;
  logic [31:0] bus_wdata_o, bus_rdata_i;
  wire [3:0] stb;
  logic [1:0] slow = 2'h0;
  int fails = 0, checks = 0, ncyc = 0, step = 1, errs;
  belane_align i_belane_align (.sys_clk_i, .reset_i, .req_valid_i, .req_ready_o,
    .req_write_i, .req_size_i, .req_addr_i, .req_wdata_i, .dev_width_i, .rsp_valid_o,
    .rsp_rdata_o, .cyc_valid_o, .cyc_done_i, .cyc_write_o, .cyc_addr_o, .bus_wdata_o,
    .bus_rdata_i, .lane3_byte_strobe_o(stb[3]), .lane2_byte_strobe_o(stb[2]),
    .lane1_byte_strobe_o(stb[1]), .lane0_byte_strobe_o(stb[0]));
  belane_mem_model i_belane_mem_model (.sys_clk_i, .cyc_valid_i(cyc_valid_o),
    .cyc_addr_i(cyc_addr_o), .stb_i(stb), .cyc_write_i(cyc_write_o), .wdata_i(bus_wdata_o),
    .width_i(dev_width_i), .slow_i(slow), .cyc_done_o(cyc_done_i), .rdata_o(bus_rdata_i),
    .errs_o(errs));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // every finished bus cycle sits one unit above the previous one
  always @(posedge sys_clk_i) begin
    if (cyc_valid_o && cyc_done_i) begin
      chk("cyc_addr", 64'(exp_addr + 29'(ncyc * step)), 64'(cyc_addr_o));
      ncyc++;
    end
  end
  // one access: ready checked, held for one clock, then a bounded wait of up to 60 clocks for completion
  task automatic acc(logic wr, belane_size_t sz, logic [28:0] a, logic [63:0] d);
    int nb, wb, n;
    nb = 1 << sz;
    wb = 1 << dev_width_i;
    step = nb < wb ? nb : wb;
    exp_addr = a;
    ncyc = 0;
    req_valid_i = 1'b1;
    req_write_i = wr;
    req_size_i = sz;
    req_addr_i = a;
    req_wdata_i = d;
    chk("ready", 64'h1, 64'(req_ready_o));
    @(posedge sys_clk_i) #1;
    req_valid_i = 1'b0;
    for (n = 0; n < 60 && rsp_valid_o !== 1'b1; n++) @(posedge sys_clk_i) #1;
    if (n == 60) begin
      fails++;
      complete_run();
    end
    rd = rsp_rdata_o;
    chk("cycles", 64'(nb > wb ? nb / wb : 1), 64'(ncyc));
  endtask
  // write, inspect the far side byte by byte, read back
  task automatic wr_rd(belane_size_t sz, logic [28:0] a, logic [63:0] d);
    int nb;
    logic [63:0] m;
    nb = 1 << sz;
    m = ~64'h0 >> (64 - nb * 8);
    acc(1'b1, sz, a, d);
    for (int i = 0; i < nb; i++) begin
      chk("mem", 64'(d[(nb-1-i)*8 +: 8]), 64'(i_belane_mem_model.mem[a+i]));
    end
    acc(1'b0, sz, a, 64'h0);
    chk("rdata", d & m, rd & m);
  endtask
  task automatic t32();
    dev_width_i = BELANE_BW_32;
    for (int o = 0; o < 4; o++) wr_rd(BELANE_SZ_BYTE, 29'(32 + o), 64'(8'h11 * (o + 1)));
    acc(1'b0, BELANE_SZ_LONG, 29'h20, 64'h0);
    chk("long32", 64'h11223344, rd & 64'hffffffff);
    wr_rd(BELANE_SZ_WORD, 29'h20, 64'hc1c2);
    wr_rd(BELANE_SZ_WORD, 29'h22, 64'hd1d2);
    wr_rd(BELANE_SZ_QUAD, 29'h28, 64'h0102030405060708);
  endtask
  // slow far side stretches every cycle by two waits
  task automatic t16();
    dev_width_i = BELANE_BW_16;
    slow = 2'h2;
    wr_rd(BELANE_SZ_BYTE, 29'h40, 64'h5a);
    wr_rd(BELANE_SZ_BYTE, 29'h41, 64'ha5);
    acc(1'b0, BELANE_SZ_WORD, 29'h40, 64'h0);
    chk("word16", 64'h5aa5, rd & 64'hffff);
    wr_rd(BELANE_SZ_LONG, 29'h44, 64'h89abcdef);
    wr_rd(BELANE_SZ_QUAD, 29'h48, 64'h1f2e3d4c5b6a7988);
  endtask
  task automatic t8();
    dev_width_i = BELANE_BW_8;
    slow = 2'h1;
    wr_rd(BELANE_SZ_BYTE, 29'h71, 64'h3c);
    wr_rd(BELANE_SZ_WORD, 29'h60, 64'hbeef);
    wr_rd(BELANE_SZ_LONG, 29'h64, 64'h76543210);
    wr_rd(BELANE_SZ_QUAD, 29'h68, 64'hf0e1d2c3b4a59687);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    t32();
    t16();
    t8();
    chk("far_errs", 64'h0, 64'(errs));
    complete_run();
  end
endmodule // testbench
